// File: src/strap_pin_logic.sv
`timescale 1ns/1ps
`include "strap_consts.svh"
// Contract
// - indicator asserted while configured and not suspended
// - indicator negated when unconfigured or suspended
// - sense low means power from upstream only
// - sense high means local supply available
// - sample strap pair at reset release
// - pair 00: all removable, indicator active high
// - pair 01: port 1 fixed, active low
// - pair 10: ports 1,2 fixed, active high
// - straps apply only in internal default modes
module strap_pin_logic
  import strap_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // multifunction pin: indicator out, power sense and strap lsb in
  input wire logic mf_pin_in,
  output logic mf_pin_out,
  output logic mf_pin_oe_out,
  // strap and setup select pins
  input wire logic fixed_port_strap_msb_in,
  input wire logic setup_select_0_in,
  input wire logic setup_select_1_in,
  // hub state from the core, same clock
  input wire logic hub_configured_in,
  input wire logic hub_suspended_in,
  // results towards the hub core
  output logic [1:0] fixed_ports_out,
  output logic indicator_active_low_out,
  output logic self_power_out,
  output logic bus_power_only_out,
  output logic strap_mode_out,
  output logic [1:0] setup_select_out,
  output logic straps_done_out,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);
  // synchronised pins
  logic [3:0] pins_sync;
  // start-up sequence state
  strap_state_t state;
  strap_state_t next_state;
  // settle counter after reset release
  logic [1:0] settle_cnt;
  // strap values caught at release
  logic [1:0] strap_pair;
  logic [1:0] sel_latched;
  // decoded strap results
  fixed_ports_t dec_fixed;
  logic dec_active_low;
  // registered decode, frozen after sampling
  fixed_ports_t strap_fixed;
  logic strap_active_low;
  // software setup register fields
  fixed_ports_t sw_fixed;
  logic sw_active_low;
  logic sw_sense_role;
  // effective polarity and port attachment
  logic eff_active_low;
  fixed_ports_t eff_fixed;
  // logical indicator state and sensed supply
  logic ind_asserted;
  logic sensed_power;
  // bus handshake
  logic bus_ack;
  logic bus_req;
  logic [31:0] status_word;
  logic [31:0] setup_word;
  logic [31:0] next_readdata;

  // bring the pins into the clock domain
  pin_sync u_pin_sync
  (
    .sys_clk_in(sys_clk_in),
    .raw_in({setup_select_1_in, setup_select_0_in, fixed_port_strap_msb_in, mf_pin_in}),
    .sync_out(pins_sync)
  );

  // table lookup of the pair
  strap_decode u_strap_decode
  (
    .pair_in(strap_pair),
    .fixed_out(dec_fixed),
    .active_low_out(dec_active_low)
  );

  // sequence: settle, sample once, then run until the next reset
  always_comb
  begin
    next_state = state;
    case (state)
      ST_SETTLE:
      begin
        // wait for the synchronisers to hold real pin levels
        if (settle_cnt == `SETTLE_CYCLES)
        begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE:
      begin
        next_state = ST_RUN;
      end
      ST_RUN:
      begin
        // stays here; only reset leaves it
        next_state = ST_RUN;
      end
      default:
      begin
        next_state = ST_SETTLE;
      end
    endcase
  end

  // state register; reset low restarts the whole sequence
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state <= ST_SETTLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // settle counter, counts only while settling
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      settle_cnt <= 2'h0;
    end
    else if (state == ST_SETTLE && settle_cnt != `SETTLE_CYCLES)
    begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  // catch the strap pair and setup selects after release; the pin is
  // still an input here, so the board resistor sets its level
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      strap_pair <= 2'h0;
      sel_latched <= 2'h0;
    end
    else if (state == ST_SETTLE && next_state == ST_SAMPLE)
    begin
      strap_pair <= pins_sync[1:0];
      sel_latched <= pins_sync[3:2];
    end
  end

  // register the decode once; held until reset afterwards
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      strap_fixed <= 2'h0;
      strap_active_low <= 1'b0;
    end
    else if (state == ST_SAMPLE)
    begin
      strap_fixed <= dec_fixed;
      strap_active_low <= dec_active_low;
    end
  end

  // straps count only in the two internal default modes
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      strap_mode_out <= 1'b0;
    end
    else if (state == ST_SAMPLE)
    begin
      strap_mode_out <= (sel_latched == `SEL_DEFAULT_SELF) ||
        (sel_latched == `SEL_DEFAULT_BUS);
    end
  end

  // choose strap or downloaded settings
  always_comb
  begin
    if (strap_mode_out)
    begin
      eff_fixed = strap_fixed;
      eff_active_low = strap_active_low;
    end
    else
    begin
      // downloaded values win, straps ignored
      eff_fixed = sw_fixed;
      eff_active_low = sw_active_low;
    end
  end

  // logical indicator: asserted only when configured and awake
  always_comb
  begin
    ind_asserted = hub_configured_in && !hub_suspended_in;
  end

  // pin drive: input until sampling is done, then the indicator unless
  // software has given the pin its power sense role
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mf_pin_out <= 1'b0;
      mf_pin_oe_out <= 1'b0;
    end
    else
    begin
      mf_pin_out <= ind_asserted ^ eff_active_low;
      mf_pin_oe_out <= (state == ST_RUN) && !sw_sense_role;
    end
  end

  // supply sense, tracked only while the pin is an input after start-up;
  // in indicator role the last reading is kept, since the pin then
  // reflects our own drive and not the board supply
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sensed_power <= 1'b0;
    end
    else if (state == ST_RUN && sw_sense_role)
    begin
      sensed_power <= pins_sync[0];
    end
  end

  // result outputs from flip-flops
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      fixed_ports_out <= 2'h0;
      indicator_active_low_out <= 1'b0;
      self_power_out <= 1'b0;
      bus_power_only_out <= 1'b1;
      setup_select_out <= 2'h0;
      straps_done_out <= 1'b0;
    end
    else
    begin
      fixed_ports_out <= eff_fixed;
      indicator_active_low_out <= eff_active_low;
      self_power_out <= sensed_power;
      bus_power_only_out <= !sensed_power;
      setup_select_out <= sel_latched;
      straps_done_out <= (state == ST_RUN);
    end
  end

  // bus request present
  always_comb
  begin
    bus_req = avs_read_in || avs_write_in;
  end

  // one wait cycle per access, then a single ack cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      bus_ack <= 1'b0;
    end
    else
    begin
      bus_ack <= bus_req && !bus_ack;
    end
  end

  // waitrequest high until the ack cycle
  always_comb
  begin
    avs_waitrequest_out = bus_req && !bus_ack;
  end

  // setup register writes, taken at the edge that ends the ack cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      {sw_sense_role, sw_active_low, sw_fixed} <= `SU_RESET;
    end
    else if (avs_write_in && bus_ack && avs_address_in == `REG_SETUP_OFS &&
      avs_byteenable_in[0])
    begin
      sw_fixed <= avs_writedata_in[`SU_FIXED_LSB +: 2];
      sw_active_low <= avs_writedata_in[`SU_POL_BIT];
      sw_sense_role <= avs_writedata_in[`SU_SENSE_BIT];
    end
  end

  // read views of status and setup
  always_comb
  begin
    status_word = 32'h0;
    status_word[`ST_PAIR_LSB +: 2] = strap_pair;
    status_word[`ST_STRAP_MODE_BIT] = strap_mode_out;
    status_word[`ST_SEL_LSB +: 2] = sel_latched;
    status_word[`ST_FIXED_LSB +: 2] = eff_fixed;
    status_word[`ST_POL_BIT] = eff_active_low;
    status_word[`ST_SELF_PWR_BIT] = sensed_power;
    status_word[`ST_IND_BIT] = ind_asserted;
    status_word[`ST_DONE_BIT] = (state == ST_RUN);
    setup_word = 32'h0;
    setup_word[`SU_FIXED_LSB +: 2] = sw_fixed;
    setup_word[`SU_POL_BIT] = sw_active_low;
    setup_word[`SU_SENSE_BIT] = sw_sense_role;
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    case (avs_address_in)
      `REG_STATUS_OFS:
      begin
        next_readdata = status_word;
      end
      `REG_SETUP_OFS:
      begin
        next_readdata = setup_word;
      end
      default:
      begin
        next_readdata = 32'h0;
      end
    endcase
  end

  // read data registered during the wait cycle, stands in the ack cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      avs_readdata_out <= 32'h0;
    end
    else if (avs_read_in && !bus_ack)
    begin
      avs_readdata_out <= next_readdata;
    end
  end
endmodule

// File: src/strap_consts.svh
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH
// register byte offsets on the avalon slave
`define REG_STATUS_OFS 4'h0
`define REG_SETUP_OFS 4'h4
// status register fields
`define ST_PAIR_LSB 0
`define ST_STRAP_MODE_BIT 2
`define ST_SEL_LSB 3
`define ST_FIXED_LSB 5
`define ST_POL_BIT 7
`define ST_SELF_PWR_BIT 8
`define ST_IND_BIT 9
`define ST_DONE_BIT 10
// setup register fields and reset values
`define SU_FIXED_LSB 0
`define SU_POL_BIT 2
`define SU_SENSE_BIT 3
`define SU_RESET 4'h0
// strap pair encodings
`define PAIR_ALL_REMOVABLE 2'h0
`define PAIR_PORT1_FIXED 2'h1
`define PAIR_BOTH_FIXED 2'h2
// setup select encodings that leave straps in force
`define SEL_DEFAULT_SELF 2'h0
`define SEL_DEFAULT_BUS 2'h2
// settle time of the pin synchronisers after reset release
`define SETTLE_CYCLES 2'h2
`endif

// File: src/strap_pkg.sv
package strap_pkg;
  // one-hot start-up sequence
  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_RUN = 3'b100
  } strap_state_t;
  // result of decoding the fixed-port strap pair
  typedef logic [1:0] fixed_ports_t;
endpackage

// File: src/pin_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for the board pins
module pin_sync
(
  // clock
  input wire logic sys_clk_in,
  // raw pins, bit 0 multifunction, 1 strap msb, 2 select 0, 3 select 1
  input wire logic [3:0] raw_in,
  // synchronised copies
  output logic [3:0] sync_out
);
  // first stage, read only by the second stage
  logic [3:0] meta;

  // no reset here on purpose: the pins must keep being tracked while
  // reset is low, so their values are ready when it is released
  always_ff @(posedge sys_clk_in)
  begin
    meta <= raw_in;
    sync_out <= meta;
  end
endmodule

// File: src/strap_decode.sv
`timescale 1ns/1ps
`include "strap_consts.svh"
// decode of the fixed-port strap pair
module strap_decode
  import strap_pkg::*;
(
  // sampled pair, msb from the dedicated strap pin
  input wire logic [1:0] pair_in,
  // bit 0 port 1 fixed, bit 1 port 2 fixed
  output fixed_ports_t fixed_out,
  // indicator asserted level is low
  output logic active_low_out
);
  // pure lookup; the caller registers the result
  always_comb
  begin
    case (pair_in)
      `PAIR_ALL_REMOVABLE:
      begin
        fixed_out = 2'h0;
        active_low_out = 1'b0;
      end
      `PAIR_PORT1_FIXED:
      begin
        fixed_out = 2'h1;
        active_low_out = 1'b1;
      end
      `PAIR_BOTH_FIXED:
      begin
        fixed_out = 2'h3;
        active_low_out = 1'b0;
      end
      default:
      begin
        // undefined pair: treat as all removable, active high
        fixed_out = 2'h0;
        active_low_out = 1'b0;
      end
    endcase
  end
endmodule

// File: testbench/strap_pin_checker.sv
`timescale 1ns/1ps
// watches the pin results of the strap block at its ports
module strap_pin_checker
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // pin and hub state
  input wire logic mf_pin_in,
  input wire logic mf_pin_out,
  input wire logic mf_pin_oe_out,
  input wire logic hub_configured_in,
  input wire logic hub_suspended_in,
  // results
  input wire logic [1:0] fixed_ports_out,
  input wire logic indicator_active_low_out,
  input wire logic self_power_out,
  input wire logic bus_power_only_out,
  input wire logic strap_mode_out,
  input wire logic [1:0] setup_select_out,
  input wire logic straps_done_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // polarity must have settled a cycle, else a setup write skews the compare
  sequence s_drive;
    straps_done_out && $past(straps_done_out) && mf_pin_oe_out && $stable(indicator_active_low_out);
  endsequence
  property p_ind_on;
    s_drive ##0 $past(hub_configured_in && !hub_suspended_in) |-> mf_pin_out == !indicator_active_low_out;
  endproperty
  a_ind_on: assert property (p_ind_on) else $error("indicator not asserted");
  property p_ind_off;
    s_drive ##0 !$past(hub_configured_in && !hub_suspended_in) |-> mf_pin_out == indicator_active_low_out;
  endproperty
  a_ind_off: assert property (p_ind_off) else $error("indicator not negated");
  property p_pwr;
    bus_power_only_out != self_power_out;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power flags disagree");
  // sense result trails the pin by the synchroniser and two registers
  property p_sense;
    (straps_done_out && !mf_pin_oe_out && $stable(mf_pin_in)) [*6] |-> self_power_out == mf_pin_in;
  endproperty
  a_sense: assert property (p_sense) else $error("sensed power wrong");
  property p_settle;
    !straps_done_out |-> ##[1:6] straps_done_out;
  endproperty
  a_settle: assert property (p_settle) else $error("start-up too slow");
  property p_pol;
    strap_mode_out && straps_done_out |-> indicator_active_low_out == (fixed_ports_out == 2'h1);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity not from pair");
  property p_ports;
    strap_mode_out && straps_done_out |-> fixed_ports_out != 2'h2;
  endproperty
  a_ports: assert property (p_ports) else $error("port 2 fixed alone");
  property p_mode;
    straps_done_out |-> strap_mode_out == !setup_select_out[0];
  endproperty
  a_mode: assert property (p_mode) else $error("strap mode wrong");
  property p_keep;
    strap_mode_out && straps_done_out && $past(straps_done_out) |->
      $stable(fixed_ports_out) && $stable(indicator_active_low_out) && $stable(setup_select_out);
  endproperty
  a_keep: assert property (p_keep) else $error("strap results moved");
  property p_start;
    !straps_done_out |-> !mf_pin_oe_out;
  endproperty
  a_start: assert property (p_start) else $error("pin driven in start-up");
  // main scenarios
  c_low: cover property (straps_done_out && strap_mode_out && indicator_active_low_out);
  c_soft: cover property (straps_done_out && !strap_mode_out);
  c_sense: cover property (straps_done_out && !mf_pin_oe_out);
endmodule

bind strap_pin_logic strap_pin_checker chk_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .mf_pin_in(mf_pin_in), .mf_pin_out(mf_pin_out), .mf_pin_oe_out(mf_pin_oe_out),
  .hub_configured_in(hub_configured_in), .hub_suspended_in(hub_suspended_in),
  .fixed_ports_out(fixed_ports_out), .indicator_active_low_out(indicator_active_low_out),
  .self_power_out(self_power_out), .bus_power_only_out(bus_power_only_out),
  .strap_mode_out(strap_mode_out), .setup_select_out(setup_select_out),
  .straps_done_out(straps_done_out));

// File: testbench/strap_board.sv
`timescale 1ns/1ps
// board side of the multifunction pin: strap resistor and supply monitor
module strap_board
(
  // pad drive from the device
  input wire logic pin_oe_in,
  input wire logic pin_drv_in,
  // board choices
  input wire logic strap_lsb_in,
  input wire logic sense_role_in,
  input wire logic supply_in,
  // resolved pad level
  output logic pin_out
);
  // the strap resistor holds an undriven pad; in sense role the supply wins
  always_comb
  begin
    if (pin_oe_in)
      pin_out = pin_drv_in;
    else if (sense_role_in)
      pin_out = supply_in;
    else
      pin_out = strap_lsb_in;
  end
endmodule

// File: testbench/suspend_power_strap_pin_logic_tb_top.sv
`timescale 1ns/1ps
`include "strap_consts.svh"
module suspend_power_strap_pin_logic_tb_top;
  logic clk = 0, rst_b = 0, msb = 0, sel0 = 0, sel1 = 0, cfg = 0, susp = 0;
  logic strap_lsb = 0, sense_role = 0, supply = 0, rd = 0, wr = 0, pin;
  logic [3:0] addr = 0, be = 4'hf;
  logic [31:0] wdata = 0, rdata, q;
  logic pin_o, pin_oe, pol, selfp, busp, mode, done, waitreq;
  logic [1:0] ports, sel;
  logic [2:0] e;
  int n_errors = 0, num_checks = 0;
  strap_pin_logic dut (.sys_clk_in(clk), .rst_b_in(rst_b), .mf_pin_in(pin), .mf_pin_out(pin_o),
    .mf_pin_oe_out(pin_oe), .fixed_port_strap_msb_in(msb), .setup_select_0_in(sel0),
    .setup_select_1_in(sel1), .hub_configured_in(cfg), .hub_suspended_in(susp),
    .fixed_ports_out(ports), .indicator_active_low_out(pol), .self_power_out(selfp),
    .bus_power_only_out(busp), .strap_mode_out(mode), .setup_select_out(sel),
    .straps_done_out(done), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq));
  strap_board board (.pin_oe_in(pin_oe), .pin_drv_in(pin_o), .strap_lsb_in(strap_lsb),
    .sense_role_in(sense_role), .supply_in(supply), .pin_out(pin));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    // waitrequest and read data are looked at on the rising edge itself
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 20);
    if (waitreq !== 1'b0)
    begin
      n_errors++;
      final_report();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // reset with board straps p (pair) and s (select)
  task automatic boot(input logic [1:0] p, input logic [1:0] s);
    int n;
    n = 0;
    @(posedge clk);
    rst_b <= 1'b0;
    {msb, strap_lsb} <= p;
    {sel1, sel0} <= s;
    {sense_role, cfg, susp} <= 3'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    while (done !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 20)
    begin
      n_errors++;
      final_report();
    end
  endtask
  // drives the hub state and looks at the pad a few cycles later
  task automatic ind(input logic c, input logic s, input logic lo);
    @(posedge clk);
    cfg <= c;
    susp <= s;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("indicator", {pin_oe, pin_o}, {1'b1, (c & ~s) ^ lo});
  endtask
  // expected {active low, fixed ports} for pair p under select s
  function automatic logic [2:0] want(input logic [1:0] p, input logic [1:0] s);
    if (s[0])
      return 3'h0;
    case (p)
      `PAIR_PORT1_FIXED: return 3'h5;
      `PAIR_BOTH_FIXED: return 3'h3;
      default: return 3'h0;
    endcase
  endfunction
  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      boot(i[1:0], i[3:2]);
      e = want(i[1:0], i[3:2]);
      chk("ports", ports, e[1:0]);
      chk("polarity", pol, e[2]);
      chk("mode", {mode, sel}, {!i[2], i[3:2]});
      bus(1'b0, `REG_STATUS_OFS, 32'h0);
      chk("status", {q[10], q[4:0]}, {1'b1, i[3:2], !i[2], i[1:0]});
      ind(1'b1, 1'b0, e[2]);
      ind(1'b1, 1'b1, e[2]);
      ind(1'b0, 1'b0, e[2]);
    end
    // select 11 left in force: setup stands in for the downloaded values;
    // the result outputs follow the write one edge after it lands
    bus(1'b1, `REG_SETUP_OFS, 32'h6);
    repeat (2) @(negedge clk);
    chk("soft", {pol, ports}, 3'h6);
    bus(1'b0, `REG_SETUP_OFS, 32'h0);
    chk("setup", q, 32'h6);
    ind(1'b1, 1'b0, 1'b1);
    boot(`PAIR_PORT1_FIXED, `SEL_DEFAULT_BUS);
    bus(1'b1, `REG_SETUP_OFS, 32'h2);
    repeat (2) @(negedge clk);
    chk("held", {pol, ports}, 3'h5);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped", q, 32'h0);
    sense_role <= 1'b1;
    supply <= 1'b1;
    bus(1'b1, `REG_SETUP_OFS, 32'h8);
    repeat (8) @(negedge clk);
    chk("local", {pin_oe, selfp, busp}, 3'h2);
    @(posedge clk);
    supply <= 1'b0;
    repeat (8) @(negedge clk);
    chk("upstream", {pin_oe, selfp, busp}, 3'h1);
    final_report();
  end
endmodule
